// [src/flash_seq_consts.svh]
`ifndef FLASH_SEQ_CONSTS_SVH
`define FLASH_SEQ_CONSTS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_NS 40
`define CLK_MHZ 25
`define NS2CYC(ns) (((ns) + `CLK_NS - 1) / `CLK_NS)
`define SETUP_NS 40
`define STROBE_NS 80
`define HOLD_NS 40
`define SETUP_CYC `NS2CYC(`SETUP_NS)
`define STROBE_CYC `NS2CYC(`STROBE_NS)
`define HOLD_CYC `NS2CYC(`HOLD_NS)
`define WINDOW_US 80
`define WINDOW_CYC (`WINDOW_US * `CLK_MHZ)

// ----------------------------------------------------------------
// register offsets and fields
// ----------------------------------------------------------------
`define REG_CFG 8'h00
`define REG_CMD 8'h04
`define REG_ADDR 8'h08
`define REG_WDATA 8'h0C
`define REG_STATUS 8'h10
`define REG_RDATA 8'h14
`define CFG_MODE16_BIT 0
`define ADDR_SEC_LSB 16
`define ST_BUSY_BIT 0
`define ST_REFUSED_BIT 1
`define ST_ERASING_BIT 2
`define ST_SUSPENDED_BIT 3
`define ST_BYPASS_BIT 4
`define ST_FAIL_BIT 5
`define ST_WINDOW_BIT 6
`define ST_READY_BIT 7

// ----------------------------------------------------------------
// bus cycle addresses and command bytes
// ----------------------------------------------------------------
`define UNLK1_A8 12'h555
`define UNLK2_A8 12'hAAA
`define UNLK1_A16 12'hAAA
`define UNLK2_A16 12'h554
`define ID_A8 12'h001
`define ID_A16 12'h002
`define PROT_A8 12'h002
`define PROT_A16 12'h004
`define CMD_UNLK1 8'hAA
`define CMD_UNLK2 8'h55
`define CMD_PROGRAM 8'hA0
`define CMD_AUTOSEL 8'h90
`define CMD_ERASE 8'h80
`define CMD_BULK 8'h10
`define CMD_SECTOR 8'h30
`define CMD_SUSPEND 8'hB0
`define CMD_RESET 8'hF0
`define CMD_BYPASS 8'h20
`define CMD_BYPASS_EXIT 8'h00
`define TOGGLE_BIT 6
`define ERROR_BIT 5

`endif

// [src/flash_seq_pkg.sv]
package flash_seq_pkg;

  // software command codes, in this order from 0
  typedef enum logic [3:0] {
    OP_READ, OP_PROGRAM, OP_READ_ID, OP_READ_PROT, OP_BULK_ERASE,
    OP_SECTOR_ERASE, OP_SECTOR_ADD, OP_SUSPEND, OP_RESUME, OP_RESET,
    OP_BYPASS_ENTER, OP_BYPASS_PROG, OP_BYPASS_EXIT, OP_POLL
  } op_t;

  typedef enum logic [2:0] {ST_IDLE, ST_ISSUE, ST_WAIT} ctl_state_t;

  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} eng_state_t;

  // one bus cycle of a command sequence
  typedef struct packed {
    logic wr;
    logic [11:0] a;
    logic [7:0] d;
    logic prog;
    logic last;
  } seq_t;

endpackage

// [src/flash_bus_cycle.sv]
`timescale 1ns/1ns
`include "flash_seq_consts.svh"
module flash_bus_cycle
  import flash_seq_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 16,
  parameter int NSEL = 12
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic wr_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] data_i,
  input wire logic [3:0] sec_i,
  output logic done_o,
  output logic [DATA_W-1:0] rdata_o,
  output logic [ADDR_W-1:0] fl_addr_o,
  output logic [DATA_W-1:0] fl_data_o,
  input wire logic [DATA_W-1:0] fl_data_i,
  output logic fl_data_oe_n_o,
  output logic write_strobe_n_o,
  output logic read_strobe_n_o,
  output logic [NSEL-1:0] sector_sel_o
);

  typedef struct packed {
    eng_state_t st;
    logic [2:0] cnt;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [NSEL-1:0] sel;
    logic drive;
    logic wr_act;
    logic rd_act;
    logic done;
    logic [DATA_W-1:0] rdata;
  } eng_t;

  eng_t q;
  eng_t d;
  logic [NSEL-1:0] onehot;

  // ----------------------------------------------------------------
  // checks and sector decode
  // ----------------------------------------------------------------
  if (`SETUP_CYC < 1 || `SETUP_CYC > 8 || `STROBE_CYC > 8 || `HOLD_CYC > 8) begin : g_chk
    $error("bus cycle phase counts out of range");
  end
  if (NSEL > 16) begin : g_chk_sel
    $error("sector count exceeds select index");
  end

  // one select per sector, one high for sec_i below NSEL, none above
  for (genvar g = 0; g < NSEL; g++) begin : g_sel
    assign onehot[g] = (sec_i == 4'(g));
  end

  // ----------------------------------------------------------------
  // cycle sequencer
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.done = 1'b0;
    unique case (q.st)
      E_IDLE: begin
        if (start_i) begin
          d.wr = wr_i;
          d.addr = addr_i;
          d.data = data_i;
          d.sel = onehot;
          d.drive = wr_i;
          d.st = E_SETUP;
          d.cnt = 3'(`SETUP_CYC - 1);
        end
      end
      E_SETUP: begin
        d.cnt = q.cnt - 3'd1;
        if (q.cnt == 3'd0) begin
          // address settles before the strobe falls [RQ18]
          d.wr_act = q.wr;
          d.rd_act = ~q.wr;
          d.st = E_STROBE;
          d.cnt = 3'(`STROBE_CYC - 1);
        end
      end
      E_STROBE: begin
        d.cnt = q.cnt - 3'd1;
        if (q.cnt == 3'd0) begin
          // data still driven as the strobe rises [RQ18]
          if (!q.wr) begin
            d.rdata = fl_data_i;
          end
          d.wr_act = 1'b0;
          d.rd_act = 1'b0;
          d.st = E_HOLD;
          d.cnt = 3'(`HOLD_CYC - 1);
        end
      end
      E_HOLD: begin
        d.cnt = q.cnt - 3'd1;
        if (q.cnt == 3'd0) begin
          d.drive = 1'b0;
          d.sel = '0;
          d.done = 1'b1;
          d.st = E_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  assign done_o = q.done;
  assign rdata_o = q.rdata;
  assign fl_addr_o = q.addr;
  assign fl_data_o = q.data;
  assign fl_data_oe_n_o = ~q.drive;
  assign write_strobe_n_o = ~q.wr_act;
  assign read_strobe_n_o = ~q.rd_act;
  assign sector_sel_o = q.sel;

endmodule

// [src/flash_seq_host.sv]
// Notes on behaviour
// (RQ1) word mode: even addresses, command in low byte only.
// (RQ2) word unlock: AAh to AAAh, 55h to 554h, command to AAAh.
// (RQ3) program: unlock pair, A0h, data to target address.
// (RQ4) protection read: 00h unprotected, 01h protected.
// (RQ5) status or id read: sector selected, fixed low address; status polls read at the REG_ADDR address instead.
// (RQ6) after error, id or protection read, F0h restores read-array.
// (RQ7) no sequence to an array that code runs from.
// (RQ8) bulk erase clears the whole addressed array.
// (RQ9) sector erase to first sector; 30h writes add more.
// (RQ10) sector adds only while the erase window is open.
// (RQ11) suspend B0h only while a sector erase runs.
// (RQ12) suspended: reads, programs outside erasing sectors, id, status; code also admits bypass entry and bypass programs.
// (RQ13) resume 30h only while suspended.
// (RQ14) bypass program A0h plus data only after bypass entry.
// (RQ15) bypass exit: 90h then 00h to the selected sector.
// (RQ16) each cycle has one active-high sector select.
// (RQ17) only address bits 11 to 0 are decoded.
// (RQ18) address taken at strobe fall, data at strobe rise.
// (RQ19) plain reads need no command cycles.
// (RQ20) bad command or long gap drops to read-array.
// (RQ21) ready/busy low during program or erase.
// (RQ22) poll bit inverted while programming, true after.
// (RQ23) toggle bit flips each read during internal write.
//
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "flash_seq_consts.svh"
module flash_seq_host
  import flash_seq_pkg::*;
#(
  parameter int NMAIN = 8,
  parameter int NSEC = 4,
  parameter int WINDOW_CYC = `WINDOW_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [11:0] fl_addr_o,
  output logic [15:0] fl_data_o,
  input wire logic [15:0] fl_data_i,
  output logic fl_data_oe_n_o,
  output logic write_strobe_n_o,
  output logic read_strobe_n_o,
  output logic [NMAIN-1:0] main_sector_select_o,
  output logic [NSEC-1:0] secondary_sector_select_o,
  input wire logic ready_busy_output_i
);

  localparam int NSEL = NMAIN + NSEC;

  typedef struct packed {
    ctl_state_t st;
    op_t op;
    logic [2:0] step;
    logic mode16;
    logic [11:0] addr;
    logic [3:0] sec;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic refused;
    logic fail;
    logic erasing;
    logic suspended;
    logic bypass;
    logic poll_seen;
    logic last_tog;
    logic [NSEL-1:0] erase_mask;
    logic [11:0] win_cnt;
    logic go;
    logic go_wr;
    logic [11:0] go_addr;
    logic [15:0] go_data;
    logic ack;
    logic [31:0] dat;
  } ctl_t;

  ctl_t q;
  ctl_t d;
  seq_t seq;
  logic eng_done;
  logic [15:0] eng_rdata;
  logic [NSEL-1:0] sel;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  if (NSEL > 16 || NMAIN < 1 || NSEC < 1) begin : g_chk_sel
    $error("sector counts not supported");
  end
  if (WINDOW_CYC < 1 || WINDOW_CYC > 4095) begin : g_chk_win
    $error("erase window count out of range");
  end

  // ----------------------------------------------------------------
  // sequence table: one bus cycle per op and step
  // ----------------------------------------------------------------
  function automatic seq_t seq_step(op_t op, logic [2:0] step, logic m16, logic [11:0] ta);
    seq_t s;
    logic [11:0] u1;
    logic [11:0] u2;
    logic pre;
    u1 = m16 ? `UNLK1_A16 : `UNLK1_A8; // [RQ2]
    u2 = m16 ? `UNLK2_A16 : `UNLK2_A8; // [RQ2]
    s.wr = 1'b1;
    s.a = u1;
    s.d = `CMD_UNLK1;
    s.prog = 1'b0;
    s.last = 1'b0;
    pre = op inside {OP_PROGRAM, OP_READ_ID, OP_READ_PROT, OP_BULK_ERASE,
                     OP_SECTOR_ERASE, OP_BYPASS_ENTER};
    if (pre && step == 3'd1) begin
      s.a = u2;
      s.d = `CMD_UNLK2;
    end
    unique case (op)
      OP_PROGRAM: begin
        if (step == 3'd2) s.d = `CMD_PROGRAM; // [RQ3]
        if (step == 3'd3) begin
          s.a = ta;
          s.prog = 1'b1;
          s.last = 1'b1;
        end
      end
      OP_READ_ID, OP_READ_PROT: begin
        if (step == 3'd2) s.d = `CMD_AUTOSEL;
        if (step == 3'd3) begin
          // fixed low address with the sector still selected [RQ5]
          s.wr = 1'b0;
          if (op == OP_READ_ID) s.a = m16 ? `ID_A16 : `ID_A8;
          else s.a = m16 ? `PROT_A16 : `PROT_A8;
        end
        if (step == 3'd4) begin
          // leave identifier mode before anything else [RQ6]
          s.a = ta;
          s.d = `CMD_RESET;
          s.last = 1'b1;
        end
      end
      OP_BULK_ERASE, OP_SECTOR_ERASE: begin
        if (step == 3'd2) s.d = `CMD_ERASE;
        if (step == 3'd4) begin
          s.a = u2;
          s.d = `CMD_UNLK2;
        end
        if (step == 3'd5) begin
          s.last = 1'b1;
          if (op == OP_BULK_ERASE) begin
            s.d = `CMD_BULK; // [RQ8]
          end else begin
            s.a = ta; // [RQ9]
            s.d = `CMD_SECTOR;
          end
        end
      end
      OP_BYPASS_ENTER: begin
        if (step == 3'd2) begin
          s.d = `CMD_BYPASS; // [RQ14]
          s.last = 1'b1;
        end
      end
      OP_BYPASS_PROG, OP_BYPASS_EXIT: begin
        s.a = ta;
        if (op == OP_BYPASS_PROG) s.d = `CMD_PROGRAM;
        else s.d = `CMD_AUTOSEL; // [RQ15]
        if (step == 3'd1) begin
          s.prog = (op == OP_BYPASS_PROG); // [RQ14]
          s.d = `CMD_BYPASS_EXIT;
          s.last = 1'b1;
        end
      end
      OP_SECTOR_ADD, OP_RESUME, OP_SUSPEND, OP_RESET: begin
        s.a = ta;
        s.last = 1'b1;
        if (op == OP_SUSPEND) s.d = `CMD_SUSPEND;
        else if (op == OP_RESET) s.d = `CMD_RESET;
        else s.d = `CMD_SECTOR; // [RQ9] [RQ13]
      end
      OP_READ, OP_POLL: begin
        // plain array or status read, no command cycles [RQ19]
        s.wr = 1'b0;
        s.a = ta;
        s.last = 1'b1;
      end
    endcase
    // even addresses only in word mode [RQ1]
    if (m16) s.a[0] = 1'b0;
    return s;
  endfunction

  // ----------------------------------------------------------------
  // command admission
  // ----------------------------------------------------------------
  function automatic logic admit(op_t op, ctl_t c, logic [NSEL-1:0] onehot);
    logic ok;
    logic run;
    run = c.erasing && !c.suspended;
    ok = (32'(c.sec) < NSEL); // [RQ16]
    unique case (op)
      OP_SECTOR_ADD: ok = ok && c.erasing && c.win_cnt != 12'h000; // [RQ10]
      OP_SUSPEND: ok = ok && run; // [RQ11]
      OP_RESUME: ok = ok && c.suspended; // [RQ13]
      OP_BYPASS_PROG: ok = ok && c.bypass && !run; // [RQ14]
      OP_PROGRAM: ok = ok && !run && !c.bypass && (c.erase_mask & onehot) == '0; // [RQ12]
      OP_BULK_ERASE, OP_SECTOR_ERASE: ok = ok && !c.erasing && !c.bypass;
      OP_READ_ID, OP_READ_PROT, OP_BYPASS_ENTER: ok = ok && !run && !c.bypass; // [RQ12]
      OP_BYPASS_EXIT: ok = ok && c.bypass;
      OP_READ, OP_POLL, OP_RESET: ok = ok;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  for (genvar g = 0; g < NSEL; g++) begin : g_onehot
    assign sel[g] = (q.sec == 4'(g));
  end

  assign seq = seq_step(q.op, q.step, q.mode16, q.addr);

  // ----------------------------------------------------------------
  // register bus and sequencer
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.ack = 1'b0;
    d.go = 1'b0;
    if (q.win_cnt != 12'h000) d.win_cnt = q.win_cnt - 12'h001;
    // classic wishbone slave, one wait state, ack one cycle
    if (wb_cyc_i && wb_stb_i && !q.ack) begin
      d.ack = 1'b1;
      d.dat = '0;
      if (wb_we_i) begin
        unique case (wb_adr_i)
          `REG_CFG: if (wb_sel_i[0] && q.st == ST_IDLE) d.mode16 = wb_dat_i[`CFG_MODE16_BIT];
          `REG_ADDR: begin
            if (wb_sel_i[0]) d.addr[7:0] = wb_dat_i[7:0];
            if (wb_sel_i[1]) d.addr[11:8] = wb_dat_i[11:8]; // [RQ17]
            if (wb_sel_i[2]) d.sec = wb_dat_i[`ADDR_SEC_LSB +: 4];
          end
          `REG_WDATA: begin
            if (wb_sel_i[0]) d.wdata[7:0] = wb_dat_i[7:0];
            if (wb_sel_i[1]) d.wdata[15:8] = wb_dat_i[15:8];
          end
          `REG_CMD: begin
            if (wb_sel_i[0] && q.st == ST_IDLE) begin
              d.fail = 1'b0;
              d.refused = !admit(op_t'(wb_dat_i[3:0]), q, sel);
              if (!d.refused) begin
                // one whole sequence, no other access in between [RQ7]
                d.op = op_t'(wb_dat_i[3:0]);
                d.step = 3'd0;
                d.poll_seen = 1'b0;
                d.st = ST_ISSUE;
                if (d.op == OP_SECTOR_ERASE) begin
                  d.erasing = 1'b1;
                  d.erase_mask = sel;
                end
                if (d.op == OP_SECTOR_ADD) d.erase_mask = q.erase_mask | sel;
                if (d.op == OP_SUSPEND) d.suspended = 1'b1;
                if (d.op == OP_RESUME) d.suspended = 1'b0;
              end
            end
          end
          default: ;
        endcase
      end else begin
        unique case (wb_adr_i)
          `REG_CFG: d.dat[`CFG_MODE16_BIT] = q.mode16;
          `REG_ADDR: d.dat = {12'h000, q.sec, 4'h0, q.addr};
          `REG_WDATA: d.dat = {16'h0000, q.wdata};
          `REG_RDATA: d.dat = {16'h0000, q.rdata};
          `REG_STATUS: begin
            d.dat[`ST_BUSY_BIT] = (q.st != ST_IDLE);
            d.dat[`ST_REFUSED_BIT] = q.refused;
            d.dat[`ST_ERASING_BIT] = q.erasing;
            d.dat[`ST_SUSPENDED_BIT] = q.suspended;
            d.dat[`ST_BYPASS_BIT] = q.bypass;
            d.dat[`ST_FAIL_BIT] = q.fail;
            d.dat[`ST_WINDOW_BIT] = (q.win_cnt != 12'h000);
            d.dat[`ST_READY_BIT] = ready_busy_output_i;
          end
          default: ;
        endcase
      end
    end
    unique case (q.st)
      ST_IDLE: ;
      ST_ISSUE: begin
        // command bytes carry a zero upper byte [RQ1]
        d.go = 1'b1;
        d.go_wr = seq.wr;
        d.go_addr = seq.a;
        d.go_data = seq.prog ? q.wdata : {8'h00, seq.d};
        d.st = ST_WAIT;
      end
      ST_WAIT: begin
        if (eng_done) begin
          d.st = ST_ISSUE;
          d.step = q.step + 3'd1;
          if (!seq.wr) d.rdata = eng_rdata; // [RQ4]
          if (q.op == OP_POLL) begin
            d.step = 3'd0;
            d.last_tog = eng_rdata[`TOGGLE_BIT];
            d.poll_seen = 1'b1;
            if (q.poll_seen && eng_rdata[`TOGGLE_BIT] == q.last_tog
                && ready_busy_output_i) begin
              // toggling stopped and device ready [RQ21] [RQ23]
              d.st = ST_IDLE;
              if (!q.suspended) begin
                d.erasing = 1'b0;
                d.erase_mask = '0;
              end
            end else if (q.poll_seen && eng_rdata[`ERROR_BIT]) begin
              // error seen: reset back to read-array [RQ6]
              d.fail = 1'b1;
              d.op = OP_RESET;
              d.erasing = 1'b0;
              d.suspended = 1'b0;
              d.erase_mask = '0;
            end
          end else if (seq.last) begin
            d.st = ST_IDLE;
            if (q.op == OP_SECTOR_ERASE || q.op == OP_SECTOR_ADD) begin
              d.win_cnt = 12'(WINDOW_CYC); // [RQ10]
            end
            if (q.op == OP_BYPASS_ENTER) d.bypass = 1'b1; // [RQ14]
            if (q.op == OP_BYPASS_EXIT) d.bypass = 1'b0; // [RQ15]
          end
        end
      end
      default: d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // bus cycle engine and outputs
  // ----------------------------------------------------------------
  logic [NSEL-1:0] pin_sel;

  flash_bus_cycle #(
    .ADDR_W(12),
    .DATA_W(16),
    .NSEL(NSEL)
  ) u_cycle (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .start_i(q.go),
    .wr_i(q.go_wr),
    .addr_i(q.go_addr),
    .data_i(q.go_data),
    .sec_i(q.sec),
    .done_o(eng_done),
    .rdata_o(eng_rdata),
    .fl_addr_o(fl_addr_o),
    .fl_data_o(fl_data_o),
    .fl_data_i(fl_data_i),
    .fl_data_oe_n_o(fl_data_oe_n_o),
    .write_strobe_n_o(write_strobe_n_o),
    .read_strobe_n_o(read_strobe_n_o),
    .sector_sel_o(pin_sel)
  );

  // exactly one select high during each cycle [RQ16]
  assign main_sector_select_o = pin_sel[NMAIN-1:0];
  assign secondary_sector_select_o = pin_sel[NSEL-1:NMAIN];
  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.dat;

endmodule

// [bench/flash_seq_asserts.sv]
`timescale 1ns/1ns
module flash_seq_asserts #(
  parameter int NMAIN = 8,
  parameter int NSEC = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [11:0] fl_addr_o,
  input wire logic [15:0] fl_data_o,
  input wire logic fl_data_oe_n_o,
  input wire logic write_strobe_n_o,
  input wire logic read_strobe_n_o,
  input wire logic [NMAIN-1:0] main_sector_select_o,
  input wire logic [NSEC-1:0] secondary_sector_select_o
);
  logic [NMAIN+NSEC-1:0] sel;
  // all sector selects as one vector
  assign sel = {secondary_sector_select_o, main_sector_select_o};
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // strobe shapes
  // ----------------------------------------------------------------
  sequence wr_pulse;
    !write_strobe_n_o [*2] ##1 write_strobe_n_o;
  endsequence
  sequence rd_pulse;
    !read_strobe_n_o [*2] ##1 read_strobe_n_o;
  endsequence
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_sel_onehot: assert property ($onehot0(sel))
    else $error("several sector selects");
  chk_wr_sel: assert property (!write_strobe_n_o |-> $onehot(sel) && !fl_data_oe_n_o)
    else $error("write without select");
  chk_rd_sel: assert property (!read_strobe_n_o |-> $onehot(sel) && fl_data_oe_n_o)
    else $error("read without select");
  chk_wr_width: assert property ($fell(write_strobe_n_o) |-> wr_pulse)
    else $error("write strobe width");
  chk_rd_width: assert property ($fell(read_strobe_n_o) |-> rd_pulse)
    else $error("read strobe width");
  chk_addr_setup: assert property ($fell(write_strobe_n_o) |-> $past(|sel) && $stable(fl_addr_o))
    else $error("address not set up");
  chk_wr_hold: assert property (!write_strobe_n_o && $past(!write_strobe_n_o)
    |-> $stable(fl_addr_o) && $stable(fl_data_o) && $stable(sel))
    else $error("write cycle moved");
  chk_rise_data: assert property ($rose(write_strobe_n_o)
    |-> (|sel && !fl_data_oe_n_o) ##1 (sel == 0 && fl_data_oe_n_o))
    else $error("data gone at strobe rise");
  chk_ack_answer: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
endmodule

// [bench/flash_dev_model.sv]
`timescale 1ns/1ns
module flash_dev_model #(
  parameter logic [15:0] ID_CODE = 16'h005A, // arbitrary value
  parameter int PROT_SEC = 2,
  parameter int BUSY_CYC = 150
) (
  input wire logic clk_i,
  input wire logic [11:0] addr_i,
  input wire logic [15:0] data_i,
  input wire logic we_n_i,
  input wire logic re_n_i,
  input wire logic [11:0] sel_i,
  output logic [15:0] data_o,
  output logic ready_o
);
  logic [15:0] mem [int];
  logic [15:0] last = 16'hFFFF;
  logic [11:0] la = 12'h000;
  logic [7:0] d;
  logic auto = 0, tog = 0, pend = 0, ers = 0;
  int busy = 0, key;
  initial data_o = 16'h0000;
  // index of the one active select
  function automatic int idx(logic [11:0] s);
    for (int i = 0; i < 12; i++) if (s[i]) return i;
    return 0;
  endfunction
  // ready low while an internal write or erase runs
  assign ready_o = (busy == 0);
  always @(posedge clk_i) if (busy > 0) busy--;
  // address taken at strobe fall, low 12 bits only
  always @(negedge we_n_i) la = addr_i;
  // data taken at strobe rise, low byte decoded
  always @(posedge we_n_i) if ($onehot(sel_i)) begin
    key = idx(sel_i) * 4096 + la;
    d = data_i[7:0];
    if (pend) begin
      mem[key] = data_i;
      last = data_i;
      busy = BUSY_CYC;
      pend = 0;
    end else if (d == 8'hA0) pend = 1;
    else if (d == 8'h80) ers = 1;
    else if (ers && (d == 8'h10 || d == 8'h30)) begin
      mem.delete();
      last = 16'hFFFF;
      busy = BUSY_CYC;
      ers = 0;
    end else if (d == 8'hB0) busy = 0;
    else if (d == 8'h30) busy = BUSY_CYC;
    else if (d == 8'h90) auto = 1;
    else if (d == 8'hF0 || d == 8'h00) auto = 0;
  end
  // read data driven from strobe fall
  always @(negedge re_n_i) if ($onehot(sel_i)) begin
    la = addr_i;
    key = idx(sel_i) * 4096 + la;
    if (busy > 0) data_o = {8'h00, ~last[7], tog, 6'h00};
    else if (auto) data_o = la[2] ? {15'h0000, idx(sel_i) == PROT_SEC} : ID_CODE;
    else data_o = mem.exists(key) ? mem[key] : 16'hFFFF;
    if (busy > 0) tog = ~tog;
  end
  // released bus shows a changing pattern
  always @(posedge re_n_i) data_o = ~data_o;
endmodule

// [bench/test_flash_seq_host.sv]
`timescale 1ns/1ns
module test_flash_seq_host;
  logic clk_i = 0;
  logic rst_i = 1;
  logic ce_i = 1;
  logic cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rv, r1;
  wire logic [31:0] rdat;
  wire logic ack, oe_n, wsn, rsn, rdy;
  wire logic [11:0] faddr;
  wire logic [15:0] fdo, fdi;
  wire logic [7:0] msel;
  wire logic [3:0] ssel;
  int fails = 0, n_compared = 0, seed = 32'h7CEB, s, key;
  int rq[5] = '{7, 8, 11, 12, 6};
  int ref_mem [int];
  logic [11:0] a;
  logic [15:0] d;
  always #20 clk_i = ~clk_i;
  flash_seq_host #(.WINDOW_CYC(20)) DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .fl_addr_o(faddr), .fl_data_o(fdo),
    .fl_data_i(fdi), .fl_data_oe_n_o(oe_n), .write_strobe_n_o(wsn), .read_strobe_n_o(rsn),
    .main_sector_select_o(msel), .secondary_sector_select_o(ssel), .ready_busy_output_i(rdy));
  flash_dev_model PEER (.clk_i(clk_i), .addr_i(faddr), .data_i(fdo), .we_n_i(wsn),
    .re_n_i(rsn), .sel_i({ssel, msel}), .data_o(fdi), .ready_o(rdy));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one classic cycle, held until ack
  task automatic bus(logic w, logic [7:0] ad, logic [31:0] dt);
    int n;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= ad;
    wdat <= dt;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      complete_run();
    end
    rv = rdat;
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask
  // set address and data, issue a command, wait until idle
  task automatic op(int c, int sc, logic [11:0] ad, logic [15:0] dt);
    int n;
    bus(1, 8'h08, {12'h000, 4'(sc), 4'h0, ad});
    bus(1, 8'h0C, {16'h0000, dt});
    bus(1, 8'h04, 32'(c));
    n = 0;
    do begin
      bus(0, 8'h10, 0);
      n++;
    end while (rv[0] !== 1'b0 && n < 500);
    if (n >= 500) begin
      fails++;
      complete_run();
    end
  endtask
  task automatic stat(string nm, int b, logic e);
    bus(0, 8'h10, 0);
    chk(nm, {31'h0, rv[b]}, {31'h0, e});
  endtask
  task automatic rdback(int sc, logic [11:0] ad);
    op(0, sc, ad, 0);
    bus(0, 8'h14, 0);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    bus(0, 8'h00, 0);
    chk("cfg", rv, 0);
    bus(0, 8'h1C, 0);
    chk("unmapped", rv, 0);
    bus(0, 8'h10, 0);
    chk("status", rv, 32'h80);
    rdback(5, 12'h123);
    chk("blank", rv, 32'hFFFF);
    // random programs in both bus modes
    for (int m = 0; m < 2; m++) begin
      bus(1, 8'h00, m);
      repeat (3) begin
        s = $unsigned($random(seed)) % 12;
        a = 12'($random(seed)) & {11'h7FF, m == 0};
        d = 16'($random(seed));
        key = s * 4096 + a;
        ref_mem[key] = d;
        op(1, s, a, d);
        stat("busy pin", 7, 0);
        rdback(s, a);
        r1 = rv;
        chk("poll bit", r1[7], !d[7]);
        rdback(s, a);
        chk("toggle", r1[6] ^ rv[6], 1);
        op(13, s, a, 0);
        rdback(s, a);
        chk("program", rv, ref_mem[key]);
      end
    end
    // code runs from the bench, never from the array under command
    for (int i = 1; i < 4; i++) begin
      op(3, i, 0, 0);
      bus(0, 8'h14, 0);
      chk("protect", rv[7:0], i == 2);
    end
    rdback(2, 12'h010);
    chk("array again", rv, 32'hFFFF);
    foreach (rq[i]) begin
      op(rq[i], 0, 0, 0);
      stat("refused", 1, 1);
    end
    op(5, 1, 12'h000, 0);
    stat("erasing", 2, 1);
    repeat (25) @(posedge clk_i);
    op(6, 2, 0, 0);
    stat("late add", 1, 1);
    op(7, 1, 0, 0);
    stat("suspended", 3, 1);
    op(1, 4, 12'h040, 16'h1234);
    op(13, 4, 12'h040, 0);
    rdback(4, 12'h040);
    chk("suspend prog", rv, 32'h1234);
    op(8, 1, 0, 0);
    stat("resumed", 3, 0);
    op(13, 1, 0, 0);
    rdback(1, 12'h000);
    chk("erased", rv, 32'hFFFF);
    op(10, 3, 0, 0);
    stat("bypass", 4, 1);
    op(1, 3, 0, 0);
    stat("prog in bypass", 1, 1);
    op(11, 3, 12'h020, 16'hBEEF);
    op(13, 3, 12'h020, 0);
    op(12, 3, 0, 0);
    stat("bypass left", 4, 0);
    rdback(3, 12'h020);
    chk("bypass prog", rv, 32'hBEEF);
    complete_run();
  end
  initial begin
    #4000000;
    fails++;
    complete_run();
  end
endmodule
bind flash_seq_host flash_seq_asserts #(.NMAIN(NMAIN), .NSEC(NSEC)) u_chk (.*);
